// *** filter_service_reminder.sv ***
// Register access over Wishbone was chosen for this implementation.
`timescale 1ns/1ns
`include "filter_service_defines.svh"

// Operation
// - fan running hours since last filter change are counted and readable.
// - software writes the allowed fan hours between filter changes.
// - hours above the interval raise the service warning and front lamp.
// - the interval reads 4000 hours after reset.
// - an interval of zero disables the hour based warning.
// - hot heatsinks raise the service warning and lamp independently of hours.
// - the heatsink condition is kept in non-volatile storage across power loss.
// - writing 1 to the clear register zeroes hours and, with the heatsink not hot, the stored heat condition.
// - with the heatsink not hot, that clear write drops the service warning and turns the lamp off.
module filter_service_reminder #(
  parameter logic [63:0] HOUR_CYCLES = `FS_HOUR_CYCLES,
  parameter int HOURS_W = 16
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire filter_service_pkg::wb_req_t wb_req_i,
  output filter_service_pkg::wb_rsp_t wb_rsp_o,
  // fan and heatsink monitor
  input wire logic fan_running_i,
  input wire logic heatsink_hot_i,
  // non-volatile storage of the heat condition
  input wire logic nv_flag_i,
  output logic nv_write_o,
  output logic nv_value_o,
  // warning outputs
  output logic service_due_o,
  output logic lamp_o
);

  import filter_service_pkg::*;

  // decode of a register index from a byte address
  function automatic logic idx_hit(input logic [17:0] adr, input logic [15:0] idx);
    idx_hit = (adr[17:2] == idx);
  endfunction

  // merge byte lanes 0 and 1 of a write into an old 16-bit value
  function automatic logic [15:0] lane_merge(
    input logic [15:0] old_val,
    input logic [31:0] wdat,
    input logic [3:0] sel
  );
    logic [15:0] res;
    res = old_val;
    if (sel[0]) begin
      res[7:0] = wdat[7:0];
    end
    if (sel[1]) begin
      res[15:8] = wdat[15:8];
    end
    lane_merge = res;
  endfunction

  // bus state
  logic ack;
  logic [31:0] rdat;
  logic next_ack;
  logic [31:0] next_rdat;
  logic access;
  logic wr_fire;
  logic clear_cmd;

  // register state
  logic [15:0] interval_hours;
  logic [HOURS_W-1:0] hours;
  logic [15:0] next_interval_hours;
  logic [HOURS_W-1:0] next_hours;

  // heat condition state
  nv_state_t nv_state;
  nv_state_t next_nv_state;
  logic temp_latched;
  logic next_temp_latched;
  logic next_nv_write;
  logic next_nv_value;

  // warning state
  logic hour_due;
  logic next_service_due;
  logic next_lamp;
  logic service_due;
  logic lamp;
  status_t status;

  // hour tick
  logic hour_tick;

  // counts running time of the fan into whole hours
  fan_hour_tick #(
    .HOUR_CYCLES(HOUR_CYCLES)
  ) u_hour_tick (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .run_i(fan_running_i),
    .clear_i(clear_cmd),
    .tick_o(hour_tick)
  );

  // an access is taken once per request, in the cycle before ack
  assign access = wb_req_i.cyc & wb_req_i.stb & ~ack;
  // a write commits at the edge at which the master samples ack, so a request dropped early changes nothing
  assign wr_fire = wb_req_i.cyc & wb_req_i.stb & wb_req_i.we & ack;

  // clear command: byte lane 0 enabled and the merged value equals one
  assign clear_cmd = wr_fire & idx_hit(wb_req_i.adr, `FS_IDX_CLEAR) & wb_req_i.sel[0]
                     & (lane_merge(16'h0, wb_req_i.dat, wb_req_i.sel) == `FS_CLEAR_CMD);

  // hour comparison, gated off by a zero interval
  assign hour_due = (interval_hours != 16'h0)
                    & (32'(hours) > 32'(interval_hours));

  // status word from the block's own state and the fan_running_i input
  always_comb begin
    status = '0;
    status.service_due = service_due;
    status.hour_due = hour_due;
    status.temp_latched = temp_latched;
    status.fan_running = fan_running_i;
  end

  // bus answer: ack one cycle after the request, read data with it
  always_comb begin
    next_ack = access;
    next_rdat = 32'h0;
    if (access & ~wb_req_i.we) begin
      if (idx_hit(wb_req_i.adr, `FS_IDX_INTERVAL)) begin
        next_rdat = {16'h0, interval_hours};
      end else if (idx_hit(wb_req_i.adr, `FS_IDX_HOURS)) begin
        next_rdat = 32'(hours);
      end else if (idx_hit(wb_req_i.adr, `FS_IDX_STATUS)) begin
        next_rdat = 32'(status);
      end else begin
        next_rdat = 32'h0;
      end
    end
  end

  // register the bus answer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack <= 1'b0;
      rdat <= 32'h0;
    end else begin
      ack <= next_ack;
      rdat <= next_rdat;
    end
  end

  // interval register and elapsed hours counter
  always_comb begin
    next_interval_hours = interval_hours;
    next_hours = hours;
    if (wr_fire & idx_hit(wb_req_i.adr, `FS_IDX_INTERVAL)) begin
      next_interval_hours = lane_merge(interval_hours, wb_req_i.dat, wb_req_i.sel);
    end
    if (clear_cmd) begin
      next_hours = '0;
    end else if (hour_tick & (hours != {HOURS_W{1'b1}})) begin
      next_hours = hours + HOURS_W'(1);
    end
  end

  // register interval and hours
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      interval_hours <= `FS_INTERVAL_RESET;
      hours <= '0;
    end else begin
      interval_hours <= next_interval_hours;
      hours <= next_hours;
    end
  end

  // heat condition: loaded from storage after reset, set wins over clear
  always_comb begin
    next_nv_state = nv_state;
    next_temp_latched = temp_latched;
    next_nv_write = 1'b0;
    next_nv_value = nv_value_o;
    unique case (nv_state)
      NV_LOAD: begin
        next_temp_latched = nv_flag_i | heatsink_hot_i;
        next_nv_value = nv_flag_i | heatsink_hot_i;
        next_nv_write = heatsink_hot_i & ~nv_flag_i;
        next_nv_state = NV_RUN;
      end
      NV_RUN: begin
        if (heatsink_hot_i) begin
          next_temp_latched = 1'b1;
        end else if (clear_cmd) begin
          next_temp_latched = 1'b0;
        end
        if (next_temp_latched != temp_latched) begin
          next_nv_write = 1'b1;
          next_nv_value = next_temp_latched;
        end
      end
    endcase
  end

  // register heat condition and storage writes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      nv_state <= NV_LOAD;
      temp_latched <= 1'b0;
      nv_write_o <= 1'b0;
      nv_value_o <= 1'b0;
    end else begin
      nv_state <= next_nv_state;
      temp_latched <= next_temp_latched;
      nv_write_o <= next_nv_write;
      nv_value_o <= next_nv_value;
    end
  end

  // warning and lamp follow either cause; a clear with the heatsink not hot drops both
  always_comb begin
    next_service_due = hour_due | temp_latched;
    next_lamp = hour_due | temp_latched;
    if (clear_cmd & ~heatsink_hot_i) begin
      next_service_due = 1'b0;
      next_lamp = 1'b0;
    end
  end

  // register warning and lamp
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      service_due <= 1'b0;
      lamp <= 1'b0;
    end else begin
      service_due <= next_service_due;
      lamp <= next_lamp;
    end
  end

  // outputs straight from flip-flops
  assign wb_rsp_o.ack = ack;
  assign wb_rsp_o.dat = rdat;
  assign service_due_o = service_due;
  assign lamp_o = lamp;

endmodule

// *** filter_service_defines.svh ***
`ifndef FILTER_SERVICE_DEFINES_SVH
`define FILTER_SERVICE_DEFINES_SVH

// register indices; byte address is four times the index
`define FS_IDX_INTERVAL 16'ha335
`define FS_IDX_CLEAR 16'ha336
`define FS_IDX_HOURS 16'ha337
`define FS_IDX_STATUS 16'ha338

// reset values and command codes
`define FS_INTERVAL_RESET 16'h0fa0
`define FS_CLEAR_CMD 16'h0001
`define FS_HOURS_RESET 16'h0000
`define FS_HOURS_MAX 16'hffff

// status register field positions
`define FS_ST_SERVICE_DUE 0
`define FS_ST_HOUR_DUE 1
`define FS_ST_TEMP_LATCHED 2
`define FS_ST_FAN_RUNNING 3

// timing: clock rate in hertz, one hour in seconds, cycles per hour
`define FS_CLK_HZ 64'h0000_0000_02fa_f080
`define FS_HOUR_S 64'h0000_0000_0000_0e10
`define FS_HOUR_CYCLES (`FS_CLK_HZ * `FS_HOUR_S)

`endif

// *** filter_service_pkg.sv ***
package filter_service_pkg;

  // classic wishbone request from the master
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [17:0] adr;
    logic [31:0] dat;
    logic [3:0] sel;
  } wb_req_t;

  // wishbone answer from this slave
  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } wb_rsp_t;

  // readable status word, service_due in bit 0
  typedef struct packed {
    logic fan_running;
    logic temp_latched;
    logic hour_due;
    logic service_due;
  } status_t;

  // non-volatile flag handling: load after reset, then run
  typedef enum logic [0:0] {
    NV_LOAD,
    NV_RUN
  } nv_state_t;

endpackage

// *** fan_hour_tick.sv ***
`timescale 1ns/1ns
`include "filter_service_defines.svh"
// counts clock cycles of fan running time and pulses once per full hour
module fan_hour_tick #(
  parameter logic [63:0] HOUR_CYCLES = `FS_HOUR_CYCLES
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // control
  input wire logic run_i,
  input wire logic clear_i,
  // one-cycle pulse per completed running hour
  output logic tick_o
);

  logic [63:0] count;
  logic [63:0] next_count;
  logic next_tick;

  // partial hours are kept while the fan stops; clear drops them
  always_comb begin
    next_count = count;
    next_tick = 1'b0;
    if (clear_i) begin
      next_count = 64'h0;
    end else if (run_i) begin
      if (count >= HOUR_CYCLES - 64'h1) begin
        next_count = 64'h0;
        next_tick = 1'b1;
      end else begin
        next_count = count + 64'h1;
      end
    end
  end

  // register the running-time counter and tick
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count <= 64'h0;
      tick_o <= 1'b0;
    end else begin
      count <= next_count;
      tick_o <= next_tick;
    end
  end

endmodule

// *** filter_service_reminder_chk.sv ***
`timescale 1ns/1ns
// watches the bus answer and the warning outputs
module filter_service_reminder_chk (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // bus and monitor inputs
  input wire filter_service_pkg::wb_req_t wb_req_i,
  input wire filter_service_pkg::wb_rsp_t wb_rsp_o,
  input wire logic heatsink_hot_i,
  // observed outputs
  input wire logic nv_write_o,
  input wire logic nv_value_o,
  input wire logic service_due_o,
  input wire logic lamp_o
);
  logic wr;
  // a write being committed, at the edge where ack is sampled high
  assign wr = wb_req_i.cyc && wb_req_i.stb && wb_req_i.we && wb_rsp_o.ack;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_req;
    wb_req_i.cyc && wb_req_i.stb && !wb_rsp_o.ack;
  endsequence
  sequence s_ack;
    wb_rsp_o.ack ##1 !wb_rsp_o.ack;
  endsequence
  a_ack_one_pulse: assert property (s_req |=> s_ack) else $error("ack not one pulse");
  a_ack_has_cause: assert property (wb_rsp_o.ack |-> $past(wb_req_i.cyc && wb_req_i.stb))
    else $error("ack without request");
  a_idle_rdat_zero: assert property (!wb_rsp_o.ack |-> wb_rsp_o.dat == 32'h0) else $error("data without ack");
  a_rdat_upper_zero: assert property (wb_rsp_o.ack |-> wb_rsp_o.dat[31:16] == 16'h0) else $error("upper bits set");
  a_lamp_tracks_due: assert property (lamp_o == service_due_o) else $error("lamp differs");
  a_hot_warns: assert property (heatsink_hot_i |-> ##2 service_due_o) else $error("heat not warned");
  a_hot_stored: assert property (heatsink_hot_i |=> nv_value_o) else $error("heat not stored");
  a_store_on_write: assert property (nv_write_o |-> $changed(nv_value_o)) else $error("store without change");
  a_drop_needs_write: assert property (!$past(rst_i) && $fell(service_due_o) |-> $past(wr) || $past(wr, 2))
    else $error("warning dropped without write");
endmodule

bind filter_service_reminder filter_service_reminder_chk chk (
  .clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req_i), .wb_rsp_o(wb_rsp_o),
  .heatsink_hot_i(heatsink_hot_i), .nv_write_o(nv_write_o), .nv_value_o(nv_value_o),
  .service_due_o(service_due_o), .lamp_o(lamp_o)
);

// *** filter_service_reminder_bench.sv ***
`timescale 1ns/1ns
// drives the reminder over its register bus and checks the warnings
module filter_service_reminder_bench;
  import filter_service_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  wb_req_t wb_req_i = '0;
  wb_rsp_t wb_rsp_o;
  logic fan_running_i = 1'b0;
  logic heatsink_hot_i = 1'b0;
  logic nv_flag_i = 1'b0;
  logic nv_write_o, nv_value_o, service_due_o, lamp_o;
  logic [15:0] rdat;
  wb_rsp_t wb_rsp_sat;
  logic [15:0] rdat_sat;
  int err_count = 0;
  int n_checks = 0;
  int cycles = 0;

  // 50 MHz clock
  always #10 clk_i = ~clk_i;

  // one hour shortened to ten cycles
  filter_service_reminder #(.HOUR_CYCLES(64'ha), .HOURS_W(16)) DUT (
    .clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req_i), .wb_rsp_o(wb_rsp_o),
    .fan_running_i(fan_running_i), .heatsink_hot_i(heatsink_hot_i), .nv_flag_i(nv_flag_i),
    .nv_write_o(nv_write_o), .nv_value_o(nv_value_o), .service_due_o(service_due_o), .lamp_o(lamp_o)
  );

  // two-bit hour count with one-cycle hours, so saturation is reached quickly
  filter_service_reminder #(.HOUR_CYCLES(64'h1), .HOURS_W(2)) DUT_SAT (
    .clk_i(clk_i), .rst_i(rst_i), .wb_req_i(wb_req_i), .wb_rsp_o(wb_rsp_sat),
    .fan_running_i(fan_running_i), .heatsink_hot_i(heatsink_hot_i), .nv_flag_i(nv_flag_i),
    .nv_write_o(), .nv_value_o(), .service_due_o(), .lamp_o()
  );

  task give_verdict;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // one counted compare
  task chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      err_count++;
    end
  endtask

  // classic single cycle, held until ack is sampled
  task bus(input logic w, input logic [15:0] idx, input logic [15:0] d);
    wb_req_i.cyc <= 1'b1;
    wb_req_i.stb <= 1'b1;
    wb_req_i.we <= w;
    wb_req_i.adr <= {idx, 2'b00};
    wb_req_i.dat <= {16'h0, d};
    wb_req_i.sel <= 4'h3;
    do @(posedge clk_i); while (wb_rsp_o.ack !== 1'b1);
    rdat = wb_rsp_o.dat[15:0];
    rdat_sat = wb_rsp_sat.dat[15:0];
    wb_req_i.cyc <= 1'b0;
    wb_req_i.stb <= 1'b0;
    @(posedge clk_i);
  endtask

  task rd_chk(input string nm, input logic [15:0] idx, input logic [15:0] exp);
    bus(1'b0, idx, 16'h0);
    chk(nm, exp, rdat);
  endtask

  // warning and lamp after they settle
  task warn_chk(input logic e);
    repeat (2) @(posedge clk_i);
    chk("service_due_o", {15'h0, e}, {15'h0, service_due_o});
    chk("lamp_o", {15'h0, e}, {15'h0, lamp_o});
  endtask

  task run_fan(input int n);
    fan_running_i <= 1'b1;
    repeat (n) @(posedge clk_i);
    fan_running_i <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask

  task do_reset;
    rst_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
  endtask

  // main sequence
  initial begin
    do_reset();
    rd_chk("interval", 16'ha335, 16'h0fa0);
    rd_chk("hours", 16'ha337, 16'h0);
    rd_chk("clear reg", 16'ha336, 16'h0);
    rd_chk("unmapped", 16'ha339, 16'h0);
    warn_chk(1'b0);
    bus(1'b1, 16'ha335, 16'h0002);
    rd_chk("interval", 16'ha335, 16'h0002);
    run_fan(25);
    rd_chk("hours", 16'ha337, 16'h0002);
    chk("hours saturated", 16'h0003, rdat_sat);
    warn_chk(1'b0);
    run_fan(10);
    rd_chk("hours", 16'ha337, 16'h0003);
    warn_chk(1'b1);
    rd_chk("status", 16'ha338, 16'h0003);
    bus(1'b1, 16'ha335, 16'h0000);
    warn_chk(1'b0);
    bus(1'b1, 16'ha335, 16'h0002);
    warn_chk(1'b1);
    bus(1'b1, 16'ha336, 16'h0002);
    rd_chk("hours", 16'ha337, 16'h0003);
    bus(1'b1, 16'ha336, 16'h0001);
    rd_chk("hours", 16'ha337, 16'h0000);
    warn_chk(1'b0);
    heatsink_hot_i <= 1'b1;
    @(posedge clk_i);
    heatsink_hot_i <= 1'b0;
    @(posedge clk_i);
    chk("nv_write_o", 16'h1, {15'h0, nv_write_o});
    warn_chk(1'b1);
    chk("nv_value_o", 16'h1, {15'h0, nv_value_o});
    rd_chk("status", 16'ha338, 16'h0005);
    nv_flag_i <= 1'b1;
    do_reset();
    warn_chk(1'b1);
    bus(1'b1, 16'ha336, 16'h0001);
    warn_chk(1'b0);
    chk("nv_value_o", 16'h0, {15'h0, nv_value_o});
    give_verdict();
  end

  // cut a hang short
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 2000) begin
      err_count++;
      give_verdict();
    end
  end
endmodule
